// ### rtl/stw_consts.vh
`ifndef STW_CONSTS_VH
`define STW_CONSTS_VH
`define STW_ID_00       8'h90
`define STW_ID_01       8'h98
`define STW_ID_10       8'hb0
`define STW_ID_11       8'hb8
`define STW_DIR_BIT     0
`define STW_IDX_W       8
`define STW_DATA_W      16
`define STW_BITS_BYTE   4'h8
`endif

// ### rtl/stw_slave.v
`include "stw_consts.vh"
module stw_slave #(
  parameter IDX_W  = `STW_IDX_W,
  parameter DATA_W = `STW_DATA_W
) (
  input  wire              clk_in,
  input  wire              arst_n_in,
  input  wire              serial_clock_in,
  input  wire              serial_data_line_in,
  output reg               serial_data_line_out,
  output reg               serial_data_line_oe_out,
  input  wire              slave_id_select_lo_in,
  input  wire              slave_id_select_hi_in,
  input  wire [DATA_W-1:0] reg_rdata_in,
  output reg  [IDX_W-1:0]  reg_index_out,
  output reg  [DATA_W-1:0] reg_wdata_out,
  output reg               reg_write_out,
  output reg               reg_read_out,
  output reg               busy_out
);
  localparam ST_IDLE = 6'b000001;
  localparam ST_ADDR = 6'b000010;
  localparam ST_RX   = 6'b000100;
  localparam ST_ACK  = 6'b001000;
  localparam ST_TX   = 6'b010000;
  localparam ST_MACK = 6'b100000;
  localparam PIN_SCL = 0;
  localparam PIN_SDA = 1;
  localparam PIN_SLO = 2;
  localparam PIN_SHI = 3;
  localparam N_PINS  = 4;

  wire [N_PINS-1:0] pin_raw;
  wire [N_PINS-1:0] pin_s;
  wire       scl_s;
  wire       sda_s;
  wire       sel_lo_s;
  wire       sel_hi_s;
  reg  scl_d_reg;
  reg  sda_d_reg;
  reg  [5:0] state_reg;
  reg  [3:0] bit_cnt_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] hi_byte_reg;
  reg        rd_reg;
  reg        idx_phase_reg;
  reg        lo_phase_reg;
  reg        ack_drive_reg;
  reg  [7:0] my_id;

  assign pin_raw = {slave_id_select_hi_in, slave_id_select_lo_in,
                    serial_data_line_in, serial_clock_in};

  // Two-stage synchronisers for every pin input
  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi = gi + 1) begin : g_sync
      stw_sync u_sync (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .d_in      (pin_raw[gi]),
        .q_out     (pin_s[gi])
      );
    end
  endgenerate

  assign scl_s    = pin_s[PIN_SCL];
  assign sda_s    = pin_s[PIN_SDA];
  assign sel_lo_s = pin_s[PIN_SLO];
  assign sel_hi_s = pin_s[PIN_SHI];

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  always @* begin
    case ({sel_hi_s, sel_lo_s})
      2'b00:   my_id = `STW_ID_00;
      2'b01:   my_id = `STW_ID_01;
      2'b10:   my_id = `STW_ID_10;
      default: my_id = `STW_ID_11;
    endcase
  end

  // Previous levels for edge and start/stop detection
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg               <= ST_IDLE;
      bit_cnt_reg             <= 4'h0;
      shift_reg               <= 8'h00;
      hi_byte_reg             <= 8'h00;
      rd_reg                  <= 1'b0;
      idx_phase_reg           <= 1'b0;
      lo_phase_reg            <= 1'b0;
      ack_drive_reg           <= 1'b0;
      serial_data_line_out    <= 1'b0;
      serial_data_line_oe_out <= 1'b0;
      reg_index_out           <= {IDX_W{1'b0}};
      reg_wdata_out           <= {DATA_W{1'b0}};
      reg_write_out           <= 1'b0;
      reg_read_out            <= 1'b0;
      busy_out                <= 1'b0;
    end else begin
      reg_write_out <= 1'b0;
      reg_read_out  <= 1'b0;
      serial_data_line_out <= 1'b0;
      if (start_ev) begin
        state_reg               <= ST_ADDR;
        bit_cnt_reg             <= 4'h0;
        serial_data_line_oe_out <= 1'b0;
        busy_out                <= 1'b1;
      end else if (stop_ev) begin
        state_reg               <= ST_IDLE;
        serial_data_line_oe_out <= 1'b0;
        busy_out                <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            serial_data_line_oe_out <= 1'b0;
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (scl_fall && bit_cnt_reg == `STW_BITS_BYTE) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == my_id[7:1]) begin
                  rd_reg        <= shift_reg[`STW_DIR_BIT];
                  idx_phase_reg <= ~shift_reg[`STW_DIR_BIT];
                  lo_phase_reg  <= 1'b0;
                  state_reg     <= ST_ACK;
                  serial_data_line_oe_out <= 1'b1;
                  if (shift_reg[`STW_DIR_BIT])
                    reg_read_out <= 1'b1;
                end else begin
                  state_reg <= ST_IDLE;
                  busy_out  <= 1'b0;
                end
              end else begin
                state_reg               <= ST_ACK;
                serial_data_line_oe_out <= 1'b1;
                if (idx_phase_reg) begin
                  reg_index_out <= shift_reg[IDX_W-1:0];
                  idx_phase_reg <= 1'b0;
                  lo_phase_reg  <= 1'b0;
                end else if (!lo_phase_reg) begin
                  hi_byte_reg  <= shift_reg;
                  lo_phase_reg <= 1'b1;
                end else begin
                  reg_wdata_out <= {hi_byte_reg, shift_reg};
                  reg_write_out <= 1'b1;
                  lo_phase_reg  <= 1'b0;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              serial_data_line_oe_out <= 1'b0;
              if (rd_reg) begin
                state_reg <= ST_TX;
                shift_reg <= lo_phase_reg ? reg_rdata_in[7:0]
                                          : reg_rdata_in[15:8];
                serial_data_line_oe_out <= lo_phase_reg
                  ? ~reg_rdata_in[7] : ~reg_rdata_in[15];
              end else begin
                state_reg <= ST_RX;
                if (ack_drive_reg) begin
                  reg_index_out <= reg_index_out + 1'b1;
                end
              end
              ack_drive_reg <= 1'b0;
            end else if (reg_write_out) begin
              ack_drive_reg <= 1'b1;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              shift_reg   <= {shift_reg[6:0], 1'b0};
              if (bit_cnt_reg == 4'h7) begin
                serial_data_line_oe_out <= 1'b0;
                state_reg <= ST_MACK;
                bit_cnt_reg <= 4'h0;
              end else begin
                serial_data_line_oe_out <= ~shift_reg[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state_reg <= ST_IDLE;
              end else begin
                state_reg <= ST_ACK;
                if (lo_phase_reg) begin
                  reg_index_out <= reg_index_out + 1'b1;
                  reg_read_out  <= 1'b1;
                end
                lo_phase_reg <= ~lo_phase_reg;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// ### rtl/stw_sync.v
module stw_sync (
  input  wire clk_in,
  input  wire arst_n_in,
  input  wire d_in,
  output wire q_out
);
  reg meta_reg;
  reg sync_reg;
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end
  assign q_out = sync_reg;
endmodule

// ### sim/stw_master_model.sv
module stw_master_model (
  input  wire clk_in,
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task q;
    repeat (2) @(posedge clk_in);
  endtask
  task bit_x(input logic b, output logic r);
    sda_low_out <= ~b;
    q;
    scl_out <= 1'b1;
    q;
    r = sda_in;
    q;
    scl_out <= 1'b0;
    q;
  endtask
  task start;
    sda_low_out <= 1'b0;
    q;
    scl_out <= 1'b1;
    q;
    sda_low_out <= 1'b1;
    q;
    scl_out <= 1'b0;
    q;
  endtask
  task stop;
    sda_low_out <= 1'b1;
    q;
    scl_out <= 1'b1;
    q;
    sda_low_out <= 1'b0;
    q;
  endtask
  task wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule

// ### sim/stw_slave_props.sv
module stw_slave_props (
  input wire clk_in,
  input wire arst_n_in,
  input wire serial_clock_in,
  input wire serial_data_line_in,
  input wire serial_data_line_out,
  input wire serial_data_line_oe_out,
  input wire reg_write_out,
  input wire reg_read_out,
  input wire busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence bus_start_s; serial_clock_in && $fell(serial_data_line_in); endsequence
  sequence bus_stop_s; serial_clock_in && $rose(serial_data_line_in); endsequence
  out_low_a: assert property (serial_data_line_out == 1'b0)
    else $error("data pin driven high");
  start_busy_a: assert property (bus_start_s |-> ##[1:6] busy_out)
    else $error("start not taken");
  stop_idle_a: assert property (bus_stop_s |-> ##[1:8] !busy_out)
    else $error("stop not taken");
  oe_clock_a: assert property ($changed(serial_data_line_oe_out) |-> !serial_clock_in)
    else $error("data drive moved with clock high");
  idle_quiet_a: assert property (!busy_out && !$past(busy_out) |-> !serial_data_line_oe_out)
    else $error("data driven while idle");
  write_pulse_a: assert property (reg_write_out |=> !reg_write_out)
    else $error("write pulse too long");
  pulse_busy_a: assert property (reg_write_out || reg_read_out |-> busy_out)
    else $error("access outside transfer");
  pulse_excl_a: assert property (!(reg_write_out && reg_read_out))
    else $error("read and write together");
endmodule
bind stw_slave stw_slave_props i_props (.*);

// ### sim/stw_slave_test.sv
module stw_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, arst_n_in, sel_lo, sel_hi, scl, m_low, ack;
  logic [15:0] rdata;
  logic [7:0]  b;
  logic [23:0] log_q[$];
  wire         oe, dout, busy, wr, rd;
  wire [7:0]   idx;
  wire [15:0]  wdata;
  wire         sda = (oe ? dout : 1'b1) & ~m_low;
  int          n_errors = 0;
  int          n_compared = 0;
  int          n_rd = 0;
  stw_slave i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .serial_clock_in(scl), .serial_data_line_in(sda),
    .serial_data_line_out(dout), .serial_data_line_oe_out(oe),
    .slave_id_select_lo_in(sel_lo), .slave_id_select_hi_in(sel_hi),
    .reg_rdata_in(rdata), .reg_index_out(idx), .reg_wdata_out(wdata),
    .reg_write_out(wr), .reg_read_out(rd), .busy_out(busy));
  stw_master_model i_m (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(m_low));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) rdata <= {8'h5a, idx};
  always @(posedge clk_in) if (wr === 1'b1) log_q.push_back({idx, wdata});
  always @(posedge clk_in) if (rd === 1'b1) n_rd++;
  task check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task t_ids;
    logic [7:0] id[4] = '{8'h90, 8'h98, 8'hb0, 8'hb8};
    for (int s = 0; s < 4; s++) begin
      {sel_hi, sel_lo} <= 2'(s);
      i_m.start;
      i_m.wr(id[s], ack);
      check(24'(ack), 24'h1);
      check(24'(busy), 24'h1);
      i_m.stop;
      i_m.start;
      i_m.wr(id[(s + 1) % 4], ack);
      check(24'(ack), 24'h0);
      check(24'(busy), 24'h0);
      i_m.wr(8'h00, ack);
      check(24'(ack), 24'h0);
      i_m.stop;
    end
  endtask
  task t_write;
    logic [7:0] wb[6] = '{8'h09, 8'h02, 8'h84, 8'h12, 8'h34, 8'h55};
    i_m.start;
    i_m.wr(8'hb8, ack);
    foreach (wb[k]) begin
      i_m.wr(wb[k], ack);
      check(24'(ack), 24'h1);
    end
    i_m.stop;
    check(24'(log_q.size()), 24'h2);
    check(log_q[0], 24'h090284);
    check(log_q[1], 24'h0a1234);
  endtask
  task t_read;
    logic [7:0] exp[4] = '{8'h5a, 8'h20, 8'h5a, 8'h21};
    i_m.start;
    i_m.wr(8'hb8, ack);
    i_m.wr(8'h20, ack);
    i_m.start;
    i_m.wr(8'hb9, ack);
    check(24'(ack), 24'h1);
    foreach (exp[k]) begin
      i_m.rd(k == 3, b);
      check(24'(b), 24'(exp[k]));
    end
    i_m.stop;
    check(24'(oe), 24'h0);
    check(24'(log_q.size()), 24'h2);
    check(24'(n_rd), 24'h2);
    repeat (4) @(posedge clk_in);
    check(24'(busy), 24'h0);
  endtask
  initial begin
    #40000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    arst_n_in = 1'b0;
    sel_lo = 1'b0;
    sel_hi = 1'b0;
    rdata = 16'h0000;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_ids;
    t_write;
    t_read;
    report_and_stop;
  end
endmodule
